// ===== hw/ncp_pkg.sv
package ncp_pkg;
  // Configuration byte indices (printed offsets); byte address is four times the index
  localparam logic [7:0] IDX_SETTLE     = 8'h3C;
  localparam logic [7:0] IDX_RSVD_A     = 8'h3D;
  localparam logic [7:0] IDX_SAMPLE     = 8'h3F;
  localparam logic [7:0] IDX_REQ_ANS    = 8'h40;
  localparam logic [7:0] IDX_FIXED_ID   = 8'h42;
  localparam logic [7:0] IDX_SEL_ANS    = 8'h45;
  localparam logic [7:0] IDX_POLL_ANS   = 8'h46;
  localparam logic [7:0] IDX_RAND_SEL   = 8'h51;
  localparam logic [7:0] IDX_RAND_ALT   = 8'h58;
  localparam logic [7:0] IDX_PWR_CTRL   = 8'h59;
  localparam logic [7:0] IDX_PWR_PERIOD = 8'h5A;
  localparam logic [7:0] IDX_TRIM       = 8'h5C;
  localparam logic [7:0] IDX_GAIN_LOOP  = 8'h5D;
  localparam logic [7:0] IDX_LAST       = 8'h5E;
  // Own control and status words
  localparam logic [7:0] IDX_CTRL       = 8'hE0;
  localparam logic [7:0] IDX_STATUS     = 8'hE1;
  localparam int         CFG_BYTES      = 35;
  localparam logic [7:0] POLL_LEN       = 8'h12;
  localparam logic [7:0] POLL_HDR0      = 8'h01;
  localparam logic [7:0] POLL_HDR1      = 8'hFE;
  localparam logic [7:0] ID_FIRST_BYTE  = 8'h08;
  localparam logic [7:0] LFSR_SEED      = 8'hA5;
  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int SETTLE_STEP_NS  = 4000;
  localparam int SAMPLE_STEP_NS  = 10000;
  localparam int SETTLE_STEP_CYC = SETTLE_STEP_NS / (1_000_000_000 / CLK_HZ);
  localparam int SAMPLE_STEP_CYC = SAMPLE_STEP_NS / (1_000_000_000 / CLK_HZ);
  // Field positions
  localparam int PWR_ON_BIT   = 0;
  localparam int STEP_LSB     = 1;
  localparam int GEAR_LSB     = 4;
  localparam int DUR_EN_BIT   = 10;
  localparam int CTRL_RF_ON   = 0;
  localparam int CTRL_CARD    = 1;
  localparam int CTRL_REQ_A   = 2;
  localparam int CTRL_SEND_F  = 3;
  typedef enum logic [1:0] {NCP_RF_OFF, NCP_RF_SETTLE, NCP_RF_DRIVE} ncp_rf_e;
endpackage : ncp_pkg

// ===== hw/ncp_config_bank.sv
// The APB register port is this design's own decision.
`timescale 1ns/10ps
// Behaviour
// - RF on waits settle byte times 4 us before driving transmitter.
// - Card mode samples external field every interval byte times 10 us.
// - Request answer sends stored byte 0 then byte 1.
// - Fixed identifier uses stored bytes 0,1,2; first byte forced to 08h.
// - Identifier check byte computed by hardware from identifier bytes.
// - Type F poll answer is 18 bytes starting 01h, FEh.
// - Random identifier enabled gives new identifier after each RF-off.
// - Random select value 0 uses stored id, 1 uses random id.
// - Power control bit 0 turns regulation off or on.
// - Power control bits 3..1 give gear step size, bit 1 LSB.
// - Power control bits 7..4 give start gear, bit 4 LSB.
// - Regulation repeats every period value ticks of timebase.
// - Trim byte corrects measured gain value used by regulation.
// - Gain loop bits 9..0 duration, bit 10 duration enable.
module ncp_config_bank
  import ncp_pkg::*;
#(
  parameter int SETTLE_UNIT_CYC = SETTLE_STEP_CYC,
  parameter int SAMPLE_UNIT_CYC = SAMPLE_STEP_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        field_detect,
  input  wire logic [15:0] gain_measured,
  output logic             tx_drive_en,
  output logic             field_present,
  output logic [7:0]       tx_byte,
  output logic             tx_byte_valid,
  output logic [7:0]       ident_byte0,
  output logic [7:0]       ident_byte1,
  output logic [7:0]       ident_byte2,
  output logic [7:0]       ident_check,
  output logic [7:0]       select_answer,
  output logic             power_regulation_on,
  output logic [2:0]       gear_step,
  output logic [3:0]       start_gear,
  output logic             regulation_tick,
  output logic [15:0]      gain_corrected,
  output logic [9:0]       gain_duration,
  output logic             gain_duration_en
);
  initial begin
    if (SETTLE_UNIT_CYC < 1 || SAMPLE_UNIT_CYC < 1)
      $error("ncp_config_bank: unit counts must be at least one cycle");
  end

  logic [7:0]  cfg [CFG_BYTES];
  logic [5:0]  ctrl;
  ncp_rf_e     rf_state;
  logic [15:0] settle_cnt;
  logic [7:0]  settle_units;
  logic [15:0] sample_cnt;
  logic [7:0]  sample_units;
  logic [15:0] period_cnt;
  logic [7:0]  lfsr;
  logic [23:0] rand_id;
  logic        rf_on_d;
  logic        req_a_d;
  logic        send_f_d;
  logic [4:0]  seq_idx;
  logic [4:0]  seq_len;
  logic        seq_f;
  logic [7:0]  widx;
  logic        acc;
  logic        hit_cfg;
  logic [7:0]  pwr_ctrl;
  logic [15:0] gain_loop;

  // Reserved words (3Dh and 3Eh) that neither take writes nor show their contents
  function automatic logic is_rsvd(input logic [7:0] idx);
    is_rsvd = (idx == IDX_RSVD_A) || (idx == 8'(IDX_RSVD_A + 8'h01));
  endfunction : is_rsvd

  // Check byte over the forced first byte and the two identifier bytes
  function automatic logic [7:0] check_of(input logic [7:0] b1, input logic [7:0] b2);
    check_of = ID_FIRST_BYTE ^ b1 ^ b2;
  endfunction : check_of

  function automatic logic [7:0] cfg_at(input logic [7:0] idx);
    cfg_at = cfg[6'(idx - IDX_SETTLE)];
  endfunction : cfg_at

  function automatic logic [15:0] cfg_word(input logic [7:0] idx);
    cfg_word = {cfg_at(8'(idx + 8'h01)), cfg_at(idx)};
  endfunction : cfg_word

  assign widx    = paddr[9:2];
  assign acc     = psel && penable;
  assign hit_cfg = (widx >= IDX_SETTLE) && (widx <= IDX_LAST);
  assign pready  = 1'b1;
  assign pwr_ctrl  = cfg_at(IDX_PWR_CTRL);
  assign gain_loop = cfg_word(IDX_GAIN_LOOP);
  assign pslverr = acc && !(hit_cfg || widx == IDX_CTRL || widx == IDX_STATUS);

  // Configuration byte store, one byte per word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CFG_BYTES; i++) cfg[i] <= 8'h00;
    end else if (acc && pwrite && hit_cfg && !is_rsvd(widx)) begin
      cfg[6'(widx - IDX_SETTLE)] <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ctrl <= 6'h00;
    else if (acc && pwrite && widx == IDX_CTRL) ctrl <= pwdata[5:0];
    else ctrl[CTRL_SEND_F:CTRL_REQ_A] <= 2'b00;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_cfg && !is_rsvd(widx))
      prdata[7:0] = cfg_at(widx);
    else if (widx == IDX_CTRL)
      prdata[1:0] = ctrl[1:0];
    else if (widx == IDX_STATUS)
      prdata = {20'h0, rf_state, field_present, tx_drive_en, lfsr};
  end

  // RF-on settle sequencing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rf_state     <= NCP_RF_OFF;
      settle_cnt   <= 16'h0000;
      settle_units <= 8'h00;
    end else begin
      case (rf_state)
        NCP_RF_OFF: begin
          settle_cnt   <= 16'h0000;
          settle_units <= 8'h00;
          if (ctrl[CTRL_RF_ON]) rf_state <= NCP_RF_SETTLE;
        end
        NCP_RF_SETTLE: begin
          if (!ctrl[CTRL_RF_ON]) rf_state <= NCP_RF_OFF;
          else if (settle_units == cfg_at(IDX_SETTLE)) rf_state <= NCP_RF_DRIVE;
          else if (settle_cnt == 16'(SETTLE_UNIT_CYC - 1)) begin
            settle_cnt   <= 16'h0000;
            settle_units <= 8'(settle_units + 8'h01);
          end else settle_cnt <= 16'(settle_cnt + 16'h0001);
        end
        NCP_RF_DRIVE: if (!ctrl[CTRL_RF_ON]) rf_state <= NCP_RF_OFF;
        default: rf_state <= NCP_RF_OFF;
      endcase
    end
  end
  assign tx_drive_en = (rf_state == NCP_RF_DRIVE);

  // External field sampling in card mode
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sample_cnt    <= 16'h0000;
      sample_units  <= 8'h00;
      field_present <= 1'b0;
    end else if (!ctrl[CTRL_CARD]) begin
      sample_cnt    <= 16'h0000;
      sample_units  <= 8'h00;
    end else if (sample_cnt != 16'(SAMPLE_UNIT_CYC - 1)) begin
      sample_cnt <= 16'(sample_cnt + 16'h0001);
    end else begin
      sample_cnt <= 16'h0000;
      if (8'(sample_units + 8'h01) >= cfg_at(IDX_SAMPLE)) begin
        sample_units  <= 8'h00;
        field_present <= field_detect;
      end else sample_units <= 8'(sample_units + 8'h01);
    end
  end

  // Random identifier, refreshed at RF-off
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lfsr    <= LFSR_SEED;
      rf_on_d <= 1'b0;
      rand_id <= 24'h00_0000;
    end else begin
      lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      rf_on_d <= ctrl[CTRL_RF_ON];
      if (rf_on_d && !ctrl[CTRL_RF_ON] && cfg_at(IDX_RAND_SEL) == 8'h01)
        rand_id <= {lfsr, ~lfsr, lfsr ^ rand_id[7:0]};
    end
  end

  // Identifier selection and check byte
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ident_byte0 <= 8'h00;
      ident_byte1 <= 8'h00;
      ident_byte2 <= 8'h00;
      ident_check <= 8'h00;
    end else begin
      ident_byte0 <= ID_FIRST_BYTE;
      if (cfg_at(IDX_RAND_SEL) == 8'h01) begin
        ident_byte1 <= rand_id[7:0];
        ident_byte2 <= rand_id[15:8];
        ident_check <= check_of(rand_id[7:0], rand_id[15:8]);
      end else begin
        ident_byte1 <= cfg_at(8'(IDX_FIXED_ID + 8'h01));
        ident_byte2 <= cfg_at(8'(IDX_FIXED_ID + 8'h02));
        ident_check <= check_of(cfg_at(8'(IDX_FIXED_ID + 8'h01)),
                                cfg_at(8'(IDX_FIXED_ID + 8'h02)));
      end
    end
  end

  // Answer byte sequencer: request answer or type F poll answer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      req_a_d  <= 1'b0;
      send_f_d <= 1'b0;
      seq_idx  <= 5'h00;
      seq_len  <= 5'h00;
      seq_f    <= 1'b0;
      tx_byte  <= 8'h00;
      tx_byte_valid <= 1'b0;
    end else begin
      req_a_d  <= ctrl[CTRL_REQ_A];
      send_f_d <= ctrl[CTRL_SEND_F];
      tx_byte_valid <= 1'b0;
      if (seq_idx != seq_len) begin
        tx_byte_valid <= 1'b1;
        seq_idx <= 5'(seq_idx + 5'h01);
        if (!seq_f) tx_byte <= cfg_at(8'(IDX_REQ_ANS + 8'(seq_idx)));
        else if (seq_idx == 5'h00) tx_byte <= POLL_HDR0;
        else if (seq_idx == 5'h01) tx_byte <= POLL_HDR1;
        else tx_byte <= cfg_at(8'(IDX_POLL_ANS + 8'(seq_idx)));
      end else if (req_a_d) begin
        seq_idx <= 5'h00;
        seq_len <= 5'h02;
        seq_f   <= 1'b0;
      end else if (send_f_d) begin
        seq_idx <= 5'h00;
        seq_len <= 5'(POLL_LEN);
        seq_f   <= 1'b1;
      end
    end
  end

  // Select answer and power regulation settings
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      select_answer       <= 8'h00;
      power_regulation_on <= 1'b0;
      gear_step           <= 3'h0;
      start_gear          <= 4'h0;
      gain_corrected      <= 16'h0000;
      gain_duration       <= 10'h000;
      gain_duration_en    <= 1'b0;
    end else begin
      select_answer       <= cfg_at(IDX_SEL_ANS);
      power_regulation_on <= pwr_ctrl[PWR_ON_BIT];
      gear_step           <= pwr_ctrl[STEP_LSB +: 3];
      start_gear          <= pwr_ctrl[GEAR_LSB +: 4];
      gain_corrected      <= 16'(gain_measured + {8'h00, cfg_at(IDX_TRIM)});
      gain_duration       <= gain_loop[9:0];
      gain_duration_en    <= gain_loop[DUR_EN_BIT];
    end
  end

  // Periodic regulation tick, one core cycle per timebase tick
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      period_cnt      <= 16'h0000;
      regulation_tick <= 1'b0;
    end else if (!pwr_ctrl[PWR_ON_BIT]) begin
      period_cnt      <= 16'h0000;
      regulation_tick <= 1'b0;
    end else if (16'(period_cnt + 16'h0001) >= cfg_word(IDX_PWR_PERIOD)) begin
      period_cnt      <= 16'h0000;
      regulation_tick <= 1'b1;
    end else begin
      period_cnt      <= 16'(period_cnt + 16'h0001);
      regulation_tick <= 1'b0;
    end
  end
endmodule : ncp_config_bank

// ===== testbench/ncp_host_model.sv
`timescale 1ns/10ps
module ncp_host_model (
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rd_data;
  logic        rd_err;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // One transfer to a byte-wide field word, then one idle edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] val);
    int n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, val};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
endmodule : ncp_host_model

// ===== testbench/ncp_props.sv
`timescale 1ns/10ps
module ncp_props
  import ncp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tx_drive_en,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_byte_valid,
  input wire logic [7:0]  ident_byte0,
  input wire logic [7:0]  ident_byte1,
  input wire logic [7:0]  ident_byte2,
  input wire logic [7:0]  ident_check,
  input wire logic        power_regulation_on,
  input wire logic [2:0]  gear_step,
  input wire logic [3:0]  start_gear,
  input wire logic [9:0]  gain_duration,
  input wire logic        gain_duration_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic       acc;
  logic       wr;
  logic [7:0] idx;
  assign acc = psel && penable && paddr[31:10] == 22'h0 && paddr[1:0] == 2'b00;
  assign wr  = acc && pwrite;
  assign idx = paddr[9:2];
  a_reserved_zero: assert property (
    acc && !pwrite && idx == IDX_RSVD_A |-> prdata == 32'h0)
    else $error("reserved word read not zero");
  a_unmapped_err: assert property (
    acc && idx == 8'h00 |-> pslverr)
    else $error("unmapped access not flagged");
  a_reg_on: assert property (
    wr && idx == IDX_PWR_CTRL |-> ##2 power_regulation_on == $past(pwdata[0], 2))
    else $error("regulation enable wrong");
  a_gear_step: assert property (
    wr && idx == IDX_PWR_CTRL |-> ##2 gear_step == $past(pwdata[3:1], 2))
    else $error("gear step wrong");
  a_start_gear: assert property (
    wr && idx == IDX_PWR_CTRL |-> ##2 start_gear == $past(pwdata[7:4], 2))
    else $error("start gear wrong");
  a_duration_low: assert property (
    wr && idx == IDX_GAIN_LOOP |-> ##2 gain_duration[7:0] == $past(pwdata[7:0], 2))
    else $error("duration low byte wrong");
  a_duration_en: assert property (
    wr && idx == IDX_LAST |-> ##2 gain_duration_en == $past(pwdata[2], 2))
    else $error("duration enable wrong");
  a_check_byte: assert property (
    ident_check == (ident_byte0 ^ ident_byte1 ^ ident_byte2))
    else $error("identifier check byte wrong");
  a_poll_header: assert property (
    wr && idx == IDX_CTRL && pwdata[3:2] == 2'b10 |->
      ##[3:5] (tx_byte_valid && tx_byte == POLL_HDR0)
      ##1 (tx_byte_valid && tx_byte == POLL_HDR1))
    else $error("poll answer header wrong");
  a_rf_off_drop: assert property (
    wr && idx == IDX_CTRL && !pwdata[0] |-> ##[1:3] !tx_drive_en)
    else $error("transmitter still driven");
endmodule : ncp_props
bind ncp_config_bank ncp_props i_props (.*);

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench
  import ncp_pkg::*;
;
  localparam int SU = 2;
  localparam int MU = 3;
  localparam logic [7:0] PV [2] = '{8'hB5, 8'h4A};
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, field_detect;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] gain_measured, gain_corrected;
  logic        tx_drive_en, field_present, tx_byte_valid, power_regulation_on;
  logic        regulation_tick, gain_duration_en;
  logic [7:0]  tx_byte, ident_byte0, ident_byte1, ident_byte2, ident_check, select_answer;
  logic [2:0]  gear_step;
  logic [3:0]  start_gear;
  logic [9:0]  gain_duration;
  logic [7:0]  got[$];
  int          n_mismatch, total_checks;
  ncp_config_bank #(.SETTLE_UNIT_CYC(SU), .SAMPLE_UNIT_CYC(MU)) i_dut (.*);
  ncp_host_model i_host (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
    total_checks++;
    if (got_v !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got_v);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    i_host.xfer(1'b1, i, v);
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Edges until sig is seen at level lv, bounded
  task automatic wait_for(ref logic sig, input logic lv, output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (sig !== lv && n < 200);
  endtask : wait_for
  task automatic grab(input int cnt);
    int n = 0;
    got.delete();
    while (got.size() < cnt && n < 100) begin
      @(negedge core_clk);
      n++;
      if (tx_byte_valid === 1'b1) got.push_back(tx_byte);
    end
  endtask : grab
  task automatic t_regs;
    wr(IDX_SEL_ANS, 8'h5C);
    i_host.xfer(1'b0, IDX_SEL_ANS, 8'h00);
    chk("sel_read", 32'h5C, i_host.rd_data);
    chk("sel_out", 8'h5C, select_answer);
    wr(IDX_RSVD_A, 8'hFF);
    i_host.xfer(1'b0, IDX_RSVD_A, 8'h00);
    chk("rsvd_read", 32'h0, i_host.rd_data);
    i_host.xfer(1'b0, 8'h00, 8'h00);
    chk("unmapped_err", 1'b1, i_host.rd_err);
  endtask : t_regs
  task automatic t_power;
    int n;
    foreach (PV[k]) begin
      wr(IDX_PWR_CTRL, PV[k]);
      cyc(2);
      chk("reg_on", PV[k][0], power_regulation_on);
      chk("gear_step", PV[k][3:1], gear_step);
      chk("start_gear", PV[k][7:4], start_gear);
    end
    wr(IDX_TRIM, 8'h10);
    gain_measured <= 16'h1234;
    wr(IDX_PWR_PERIOD, 8'h04);
    wr(IDX_PWR_PERIOD + 8'h01, 8'h00);
    wr(IDX_PWR_CTRL, 8'h01);
    chk("gain_corrected", 16'h1234 + 16'h0010, gain_corrected);
    repeat (2) wait_for(regulation_tick, 1'b1, n);
    chk("tick_gap", 32'd4, n);
    wr(IDX_GAIN_LOOP, 8'h34);
    wr(IDX_LAST, 8'h07);
    cyc(2);
    chk("duration", {2'b11, 8'h34}, gain_duration);
    chk("duration_en", 1'b1, gain_duration_en);
  endtask : t_power
  task automatic t_answer;
    wr(IDX_REQ_ANS, 8'h44);
    wr(IDX_REQ_ANS + 8'h01, 8'h03);
    for (int i = 0; i < 16; i++) wr(8'h48 + 8'(i), 8'h20 + 8'(i));
    wr(IDX_CTRL, 8'h04);
    grab(2);
    chk("req_first", 8'h44, got[0]);
    chk("req_second", 8'h03, got[1]);
    wr(IDX_CTRL, 8'h08);
    grab(18);
    for (int i = 0; i < 18; i++)
      chk("poll_byte", i == 0 ? POLL_HDR0 : i == 1 ? POLL_HDR1 : 8'h1E + 8'(i), got[i]);
  endtask : t_answer
  task automatic t_ident;
    logic [15:0] r;
    for (int i = 0; i < 3; i++) wr(IDX_FIXED_ID + 8'(i), 8'h11 * 8'(i + 1));
    cyc(2);
    chk("id0", ID_FIRST_BYTE, ident_byte0);
    chk("id12", 16'h2233, {ident_byte1, ident_byte2});
    chk("id_check", ID_FIRST_BYTE ^ 8'h22 ^ 8'h33, ident_check);
    wr(IDX_RAND_SEL, 8'h01);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h00);
    cyc(2);
    r = {ident_byte1, ident_byte2};
    wr(IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h00);
    cyc(2);
    chk("rand_new", 1'b1, {ident_byte1, ident_byte2} != r);
    wr(IDX_RAND_SEL, 8'h00);
    cyc(2);
    chk("fixed_back", 16'h2233, {ident_byte1, ident_byte2});
  endtask : t_ident
  task automatic t_timing;
    int n;
    wr(IDX_SETTLE, 8'd5);
    wr(IDX_CTRL, 8'h01);
    wait_for(tx_drive_en, 1'b1, n);
    chk("settle_wait", 1'b1, n >= 5 * SU - 1 && n <= 5 * SU + 4);
    wr(IDX_SAMPLE, 8'd2);
    wr(IDX_CTRL, 8'h02);
    field_detect <= 1'b1;
    wait_for(field_present, 1'b1, n);
    field_detect <= 1'b0;
    wait_for(field_present, 1'b0, n);
    chk("sample_gap", 1'b1, n >= 2 * MU - 2 && n <= 2 * MU + 1);
  endtask : t_timing
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    reset = 1'b1;
    field_detect = 1'b0;
    gain_measured = 16'h0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_regs();
    $display("done registers");
    t_power();
    $display("done regulation");
    t_answer();
    $display("done answers");
    t_ident();
    $display("done identifier");
    t_timing();
    $display("done timing");
    report_and_stop();
  end
endmodule : testbench
